// File: wakeup_filter_pkg.sv
// shared constants, types and helper functions for the wake-up pattern filter
// assumes a single 40 MHz clock domain and a synchronous active-high reset
package wakeup_filter_pkg;

  localparam int NUM_FILTERS = 4;
  localparam int LOAD_WORDS  = 8;

  // load sequence positions on the power-management port
  localparam logic [2:0] IDX_MASK0  = 3'h0;
  localparam logic [2:0] IDX_CMD    = 3'h4;
  localparam logic [2:0] IDX_OFFSET = 3'h5;
  localparam logic [2:0] IDX_SIG01  = 3'h6;
  localparam logic [2:0] IDX_SIG23  = 3'h7;
  localparam logic [2:0] IDX_LAST   = 3'h7;

  // command byte fields
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_CHAIN_BIT  = 2;
  localparam int CMD_MCAST_BIT  = 3;

  // field widths and placement inside the packed words
  localparam int BYTE_W = 8;
  localparam int SIG_W  = 16;

  // a single filter looks at most this many bytes past its offset
  localparam logic [8:0] WINDOW_BYTES = 9'h01F;

  // destination group bit sits in bit 0 of the first frame byte
  localparam int GROUP_BIT = 0;

  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;

  // reflected crc16 generator and seed
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  typedef logic [LOAD_WORDS-1:0][31:0] load_words_t;

  typedef struct packed {
    logic [31:0] select;
    logic [7:0]  cmd;
    logic [7:0]  offset;
    logic [15:0] sig;
  } filter_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } rx_beat_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RECV  = 3'b010,
    ST_CHECK = 3'b100
  } rx_state_e;

  // one byte of the reflected crc16, lsb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int b = 0; b < 8; b++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// File: filter_word_store.sv
// holds the eight loaded configuration words of the pattern filter
// assumes writes arrive one per cycle with an index from the load sequencer
`timescale 1ns/100ps
module filter_word_store
  import wakeup_filter_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  wr_idx_i,
  input  wire logic [31:0] wr_data_i,
  output load_words_t      words_o
);

  load_words_t words_ff;
  load_words_t nxt_words;

  // write one word in place, others hold
  always_comb
  begin
    nxt_words = words_ff;
    if (wr_en_i)
    begin
      nxt_words[wr_idx_i] = wr_data_i;
    end
  end

  // cleared store reads as all filters unused
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      words_ff <= {LOAD_WORDS{WORD_RESET}};
    end
    else
    begin
      words_ff <= nxt_words;
    end
  end

  assign words_o = words_ff;

endmodule

// File: wakeup_frame_pattern_filter.sv
// wake-up frame pattern filter: four crc16 pattern filters loaded over one port
// assumes rx bytes and the address recognition verdict come synchronous to mclk_i
//
// Summary of operation
// - mask bit i selects frame byte offset+i
// - offset word holds one byte per filter
// - command byte: enable, multicast, per filter
// - chained filter matches only with previous match
// - crc16 of selected bytes compared with signature
// - one filter spans only 31 bytes
// - destination address left to address recognition
`timescale 1ns/100ps
module wakeup_frame_pattern_filter
  import wakeup_filter_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        pm_load_wr_i,
  input  wire logic [31:0] pm_load_data_i,
  input  wire logic        pm_load_restart_i,
  input  rx_beat_s         rx_beat_i,
  input  wire logic        rx_addr_pass_i,
  output logic [2:0]       load_index_o,
  output logic             load_done_o,
  output logic             wake_event_o,
  output logic [3:0]       filter_match_o
);

  load_words_t                   words;
  filter_cfg_s [NUM_FILTERS-1:0] cfg;

  logic [2:0] ptr_ff;
  logic [2:0] nxt_ptr;
  logic       done_ff;
  logic       nxt_done;

  rx_state_e                    state_ff;
  rx_state_e                    nxt_state;
  logic [7:0]                   cnt_ff;
  logic [7:0]                   nxt_cnt;
  logic                         mcast_ff;
  logic                         nxt_mcast;
  logic                         addr_ok_ff;
  logic                         nxt_addr_ok;
  logic [NUM_FILTERS-1:0][15:0] crc_ff;
  logic [NUM_FILTERS-1:0][15:0] nxt_crc;

  logic       wake_ff;
  logic       nxt_wake;
  logic [3:0] match_ff;
  logic [3:0] nxt_match;
  logic [3:0] own_hit;
  logic [3:0] chain_hit;
  logic [3:0] group_end;

  // filter takes part in matching at all
  function automatic logic is_enabled(input filter_cfg_s f);
    return f.cmd[CMD_ENABLE_BIT];
  endfunction

  // filter only counts together with the one below it
  function automatic logic is_chained(input filter_cfg_s f);
    return f.cmd[CMD_CHAIN_BIT];
  endfunction

  // next byte position, held at the top so long frames never re-enter a window
  function automatic logic [7:0] step_pos(input logic [7:0] pos);
    return (pos != CNT_MAX) ? pos + 8'h01 : pos;
  endfunction

  // true when frame byte pos is picked by this filter's mask
  function automatic logic byte_selected(input filter_cfg_s f, input logic [7:0] pos);
    logic [8:0] rel;
    rel = {1'b0, pos} - {1'b0, f.offset};
    // bytes before the offset or past the window never count
    return (pos >= f.offset) && (rel < WINDOW_BYTES) && f.select[rel[4:0]];
  endfunction

  // filter applies only to the frame kind its command names
  function automatic logic kind_ok(input filter_cfg_s f, input logic mcast);
    return is_enabled(f) && (f.cmd[CMD_MCAST_BIT] == mcast);
  endfunction

  filter_word_store u_store (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .wr_en_i   (pm_load_wr_i),
    .wr_idx_i  (ptr_ff),
    .wr_data_i (pm_load_data_i),
    .words_o   (words)
  );

  // unpack the eight words into per-filter fields, filter 0 in the low lane
  always_comb
  begin
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      cfg[i].select = words[IDX_MASK0 + 3'(i)];
      cfg[i].cmd    = words[IDX_CMD][i*BYTE_W +: BYTE_W];
      cfg[i].offset = words[IDX_OFFSET][i*BYTE_W +: BYTE_W];
      cfg[i].sig    = (i < 2) ? words[IDX_SIG01][(i%2)*SIG_W +: SIG_W]
                              : words[IDX_SIG23][(i%2)*SIG_W +: SIG_W];
    end
  end

  // load sequencer: eight successive writes, then wraps for the next load
  always_comb
  begin
    nxt_ptr  = ptr_ff;
    nxt_done = done_ff;
    // restart wins over a write in the same cycle; that write still lands at the old index
    if (pm_load_restart_i)
    begin
      nxt_ptr  = IDX_MASK0;
      nxt_done = 1'b0;
    end
    else if (pm_load_wr_i)
    begin
      nxt_ptr = ptr_ff + 3'h1;
      if (ptr_ff == IDX_LAST)
      begin
        nxt_done = 1'b1;
      end
      else if (ptr_ff == IDX_MASK0)
      begin
        nxt_done = 1'b0;
      end
    end
  end

  // load sequencer registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ptr_ff  <= IDX_MASK0;
      done_ff <= 1'b0;
    end
    else
    begin
      ptr_ff  <= nxt_ptr;
      done_ff <= nxt_done;
    end
  end

  // receive walk: count bytes and fold selected ones into each crc
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_mcast   = mcast_ff;
    nxt_addr_ok = addr_ok_ff;
    nxt_crc     = crc_ff;
    unique case (state_ff)
      ST_IDLE, ST_RECV:
      begin
        if (rx_beat_i.valid && (rx_beat_i.sof || state_ff == ST_RECV))
        begin
          // a start byte restarts in idle or receive, even in mid-frame
          if (rx_beat_i.sof)
          begin
            nxt_cnt   = 8'h00;
            nxt_mcast = rx_beat_i.data[GROUP_BIT];
            for (int i = 0; i < NUM_FILTERS; i++)
            begin
              nxt_crc[i] = byte_selected(cfg[i], 8'h00) ? crc16_byte(CRC_INIT, rx_beat_i.data) : CRC_INIT;
            end
          end
          else
          begin
            for (int i = 0; i < NUM_FILTERS; i++)
            begin
              if (byte_selected(cfg[i], cnt_ff))
              begin
                nxt_crc[i] = crc16_byte(crc_ff[i], rx_beat_i.data);
              end
            end
          end
          // saturate so long frames do not wrap into the window again
          if (!rx_beat_i.sof)
          begin
            nxt_cnt = step_pos(cnt_ff);
          end
          if (rx_beat_i.sof && rx_beat_i.eof)
          begin
            nxt_cnt = 8'h00;
          end
          // address verdict is only taken with the last byte
          nxt_state = rx_beat_i.eof ? ST_CHECK : ST_RECV;
          if (rx_beat_i.eof)
          begin
            nxt_addr_ok = rx_addr_pass_i;
          end
        end
        if (rx_beat_i.valid && !rx_beat_i.sof && state_ff == ST_RECV)
        begin
          // counter now names the position of the next byte
          nxt_cnt = step_pos(cnt_ff);
        end
        if (rx_beat_i.valid && rx_beat_i.sof)
        begin
          nxt_cnt = 8'h01;
        end
      end
      ST_CHECK:
      begin
        // one verdict cycle; a start byte here is dropped
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // receive walk registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 8'h00;
      mcast_ff   <= 1'b0;
      addr_ok_ff <= 1'b0;
      crc_ff     <= {NUM_FILTERS{CRC_INIT}};
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      mcast_ff   <= nxt_mcast;
      addr_ok_ff <= nxt_addr_ok;
      crc_ff     <= nxt_crc;
    end
  end

  // per-filter verdict; a zeroed filter is disabled and never hits
  always_comb
  begin
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      own_hit[i] = kind_ok(cfg[i], mcast_ff) && (crc_ff[i] == cfg[i].sig);
    end
    chain_hit[0] = own_hit[0];
    for (int i = 1; i < NUM_FILTERS; i++)
    begin
      chain_hit[i] = own_hit[i] && (!is_chained(cfg[i]) || chain_hit[i-1]);
    end
    // a hit that feeds an enabled chained successor only counts through its group
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      group_end[i] = (i == NUM_FILTERS - 1)
                     || !(is_chained(cfg[(i+1)%NUM_FILTERS]) && is_enabled(cfg[(i+1)%NUM_FILTERS]));
    end
  end

  // wake decision once per frame, in the cycle after its last byte
  always_comb
  begin
    nxt_wake  = 1'b0;
    nxt_match = match_ff;
    if (state_ff == ST_CHECK)
    begin
      nxt_match = chain_hit;
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        // only the last filter of a chained group may wake
        if (chain_hit[i] && group_end[i])
        begin
          nxt_wake = addr_ok_ff;
        end
      end
      if (!addr_ok_ff)
      begin
        nxt_wake = 1'b0;
      end
    end
  end

  // verdict registers feed the outputs directly
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wake_ff  <= 1'b0;
      match_ff <= 4'h0;
    end
    else
    begin
      wake_ff  <= nxt_wake;
      match_ff <= nxt_match;
    end
  end

  assign load_index_o   = ptr_ff;
  assign load_done_o    = done_ff;
  assign wake_event_o   = wake_ff;
  assign filter_match_o = match_ff;

endmodule

// File: wakeup_filter_properties.sv
// port assertions for the wake-up pattern filter
// assumes one clock and the synchronous active-high reset of the top module
`timescale 1ns/100ps
module wakeup_filter_properties
  import wakeup_filter_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        pm_load_wr_i,
  input wire logic [31:0] pm_load_data_i,
  input wire logic        pm_load_restart_i,
  input rx_beat_s         rx_beat_i,
  input wire logic        rx_addr_pass_i,
  input wire logic [2:0]  load_index_o,
  input wire logic        load_done_o,
  input wire logic        wake_event_o,
  input wire logic [3:0]  filter_match_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // load port sequencing
  a_index_step: assert property (pm_load_wr_i && !pm_load_restart_i |=>
    load_index_o == 3'($past(load_index_o) + 3'h1)) else $error("load index did not step");
  a_index_hold: assert property (!pm_load_wr_i && !pm_load_restart_i |=>
    $stable(load_index_o)) else $error("load index moved without a write");
  a_restart_zero: assert property (pm_load_restart_i |=> load_index_o == 3'h0 && !load_done_o)
    else $error("restart did not clear the sequencer");
  a_done_rise: assert property (pm_load_wr_i && !pm_load_restart_i && load_index_o == 3'h7
    |=> load_done_o) else $error("load done missing after last word");
  a_done_clear: assert property (pm_load_wr_i && !pm_load_restart_i && load_index_o == 3'h0
    |=> !load_done_o) else $error("load done not cleared by a new load");
  // wake event timing, two edges after the eof beat
  a_wake_pulse: assert property (wake_event_o |=> !wake_event_o)
    else $error("wake event longer than one cycle");
  a_wake_cause: assert property (wake_event_o |->
    $past(rx_beat_i.valid && rx_beat_i.eof && rx_addr_pass_i, 2)) else $error("wake without passed frame");
  a_wake_match: assert property (wake_event_o |-> filter_match_o != 4'h0)
    else $error("wake with no filter hit");
  a_match_hold: assert property (!$past(reset_i) && !$past(rx_beat_i.valid && rx_beat_i.eof, 2) |->
    $stable(filter_match_o)) else $error("match changed outside a check");
endmodule

bind wakeup_frame_pattern_filter wakeup_filter_properties wakeup_filter_properties_i (.*);

// File: wakeup_frame_source.sv
// frame source standing in for the receive path and address recognition
// assumes the bench calls send between idle gaps
`timescale 1ns/100ps
module wakeup_frame_source
  import wakeup_filter_pkg::*;
(
  input  wire logic mclk_i,
  output rx_beat_s  rx_beat_o,
  output logic      addr_pass_o
);
  // idle at time zero
  initial
  begin
    rx_beat_o   = '0;
    addr_pass_o = 1'b0;
  end

  // 20-byte frame; type bytes 08 00 at 12, ff ff at 14 (first FF is broadcast)
  task automatic send(input logic [7:0] first, input logic pass);
    logic [7:0] b;
    for (int i = 0; i < 20; i++)
    begin
      b = (i == 0) ? first : (i == 12) ? 8'h08 : (i == 13) ? 8'h00 : (i == 14 || i == 15) ? 8'hFF : 8'(i);
      @(posedge mclk_i);
      rx_beat_o   <= '{1'b1, i == 0, i == 19, b};
      addr_pass_o <= pass;
    end
    // released lines show the inverse, not a held value
    @(posedge mclk_i);
    rx_beat_o   <= '{1'b0, 1'b0, 1'b0, ~b};
    addr_pass_o <= ~pass;
  endtask
endmodule

// File: wakeup_frame_pattern_filter_bench.sv
// self-checking bench for the wake-up pattern filter
// assumes the frame source model and the bound checker
`timescale 1ns/100ps
module wakeup_frame_pattern_filter_bench;
  import wakeup_filter_pkg::*;

  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] sig;
    logic [7:0]  first;
    logic        pass;
    logic        wake;
    logic [3:0]  match;
    logic        chk;
  } row_s;

  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        pm_load_wr_i = 1'b0;
  logic [31:0] pm_load_data_i = 32'h00000000;
  logic        pm_load_restart_i = 1'b0;
  rx_beat_s    rx_beat_i;
  logic        rx_addr_pass_i;
  logic [2:0]  load_index_o;
  logic        load_done_o;
  logic        wake_event_o;
  logic [3:0]  filter_match_o;
  logic [15:0] s0;
  logic [15:0] s1;
  row_s        rows [8];
  int          err_count = 0;
  int          checks_done = 0;

  wakeup_frame_pattern_filter wakeup_frame_pattern_filter_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .pm_load_wr_i(pm_load_wr_i), .pm_load_data_i(pm_load_data_i), .pm_load_restart_i(pm_load_restart_i),
    .rx_beat_i(rx_beat_i), .rx_addr_pass_i(rx_addr_pass_i), .load_index_o(load_index_o),
    .load_done_o(load_done_o), .wake_event_o(wake_event_o), .filter_match_o(filter_match_o));
  wakeup_frame_source wakeup_frame_source_i (.mclk_i(mclk_i), .rx_beat_o(rx_beat_i), .addr_pass_o(rx_addr_pass_i));

  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // eight words in order; unused filters 2 and 3 get zero mask and crc
  task automatic load(input logic [31:0] c, input logic [31:0] s);
    logic [31:0] w [8];
    w = '{32'h00000003, 32'h00000003, 32'h0, 32'h0, c, 32'h00000E0C, s, 32'h0};
    for (int k = 0; k < 8; k++)
    begin
      @(posedge mclk_i);
      pm_load_wr_i   <= 1'b1;
      pm_load_data_i <= w[k];
      #1 cmp("index", 8'(k), 8'(load_index_o));
    end
    @(posedge mclk_i);
    pm_load_wr_i <= 1'b0;
    #1 cmp("done", 8'h01, 8'(load_done_o));
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #500000;
    err_count++;
    stop_test();
  end

  // main sequence: table rows, then restart and reset
  initial
  begin
    s0 = 16'h7006; // signature of bytes 08 00
    s1 = 16'h0000; // signature of bytes ff ff
    rows = '{'{32'h01, {16'h0, s0}, 8'h00, 1'b1, 1'b1, 4'h1, 1'b1},
             '{32'h01, {16'h0, s0}, 8'h00, 1'b0, 1'b0, 4'h1, 1'b1},
             '{32'h01, {16'h0, s0}, 8'h01, 1'b1, 1'b0, 4'h0, 1'b1},
             '{32'h01, {16'h0, ~s0}, 8'h00, 1'b1, 1'b0, 4'h0, 1'b1},
             '{32'h09, {16'h0, s0}, 8'hFF, 1'b1, 1'b1, 4'h1, 1'b1},
             '{32'h0900, {s1, 16'h0}, 8'hFF, 1'b1, 1'b1, 4'h2, 1'b1},
             '{32'h0D09, {s1, s0}, 8'hFF, 1'b1, 1'b1, 4'h3, 1'b1},
             '{32'h0D09, {~s1, s0}, 8'hFF, 1'b1, 1'b0, 4'h1, 1'b1}};
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 cmp("rst match", 8'h00, 8'(filter_match_o));
    for (int r = 0; r < 8; r++)
    begin
      load(rows[r].cmd, rows[r].sig);
      wakeup_frame_source_i.send(rows[r].first, rows[r].pass);
      @(posedge mclk_i); // wake stands only in the cycle after the check
      #1 cmp("wake", 8'(rows[r].wake), 8'(wake_event_o));
      if (rows[r].chk)
        cmp("match", 8'(rows[r].match), 8'(filter_match_o));
      $display("row %0d done", r);
    end
    // restart mid-load
    @(posedge mclk_i);
    pm_load_wr_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    pm_load_wr_i      <= 1'b0;
    pm_load_restart_i <= 1'b1;
    @(posedge mclk_i);
    pm_load_restart_i <= 1'b0;
    #1 cmp("rs index", 8'h00, 8'(load_index_o));
    cmp("rs done", 8'h00, 8'(load_done_o));
    $display("restart done");
    // second reset clears the loaded state
    load(32'h09, {16'h0, s0});
    @(posedge mclk_i);
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 cmp("reset done", 8'h00, 8'(load_done_o));
    wakeup_frame_source_i.send(8'hFF, 1'b1);
    @(posedge mclk_i);
    #1 cmp("reset wake", 8'h00, 8'(wake_event_o));
    $display("reset done");
    stop_test();
  end
endmodule
